/* srf_defines.svh */
/*
 * Address, field and reset constants for the status and rate/filter registers.
 * Assumes inclusion by bare name from every design file that needs them.
 */
`ifndef SRF_DEFINES_SVH
`define SRF_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------------
`define SRF_ADDR_STATUS      5'h01
`define SRF_ADDR_RATE_FILT   5'h02

// ----------------------------------------------------------------------------
// Status bit positions
// ----------------------------------------------------------------------------
`define SRF_ST_LOCK          7
`define SRF_ST_CRC           6
`define SRF_ST_AMP_LO        5
`define SRF_ST_AMP_HI        4
`define SRF_ST_VREF_LO       3
`define SRF_ST_NEW_DATA      2
`define SRF_ST_CLOCK         1
`define SRF_ST_RESET         0

// ----------------------------------------------------------------------------
// Rate/filter fields and reset values
// ----------------------------------------------------------------------------
`define SRF_RATE_HI          7
`define SRF_RATE_LO          3
`define SRF_FILT_HI          2
`define SRF_FILT_LO          0
`define SRF_RATE_FILT_RST    8'h24
`define SRF_FILT_LAST_LEGAL  3'h4
`define SRF_RATE_TOP_BIT     4

`endif

/* srf_pkg.sv */
/*
 * Types shared by the status and rate/filter register bank.
 * Assumes srf_defines.svh is on the include path.
 */
package srf_pkg;

    // Filter selection
    typedef enum logic [2:0] {
        SRF_FILT_SINC1 = 3'h0,
        SRF_FILT_SINC2 = 3'h1,
        SRF_FILT_SINC3 = 3'h2,
        SRF_FILT_SINC4 = 3'h3,
        SRF_FILT_FIR   = 3'h4
    } srf_filter_t;

    // Decoded output rate in tenths of samples per second
    typedef logic [19:0] srf_rate_t;

endpackage

/* srf_rate_decode.sv */
/*
 * Decodes the five-bit rate code into samples per second (tenths).
 * Assumes a purely combinational use by the register bank.
 */
`include "srf_defines.svh"

module srf_rate_decode
    import srf_pkg::*;
(
    // Code in
    input  wire logic [4:0] rate_code,
    // Rate out
    output srf_rate_t       rate_dsps
);

    always_comb begin
        rate_dsps = 20'h61a80;
        if (!rate_code[`SRF_RATE_TOP_BIT]) begin
            unique case (rate_code[3:0])
                4'h0: rate_dsps = 20'h00019;
                4'h1: rate_dsps = 20'h00032;
                4'h2: rate_dsps = 20'h00064;
                4'h3: rate_dsps = 20'h000a6;
                4'h4: rate_dsps = 20'h000c8;
                4'h5: rate_dsps = 20'h001f4;
                4'h6: rate_dsps = 20'h00258;
                4'h7: rate_dsps = 20'h003e8;
                4'h8: rate_dsps = 20'h00fa0;
                4'h9: rate_dsps = 20'h02ee0;
                4'ha: rate_dsps = 20'h05dc0;
                4'hb: rate_dsps = 20'h0bb80;
                4'hc: rate_dsps = 20'h11940;
                4'hd: rate_dsps = 20'h23280;
                4'he: rate_dsps = 20'h2ee00;
                4'hf: rate_dsps = 20'h3e800;
            endcase
        end
    end

endmodule

/* srf_filter_decode.sv */
/*
 * Decodes the three-bit filter field and flags reserved codes.
 * Assumes a purely combinational use by the register bank.
 */
`include "srf_defines.svh"

module srf_filter_decode
    import srf_pkg::*;
(
    // Code in
    input  wire logic [2:0] filt_code,
    // Decoded
    output srf_filter_t     filt_sel,
    output logic            filt_reserved
);

    always_comb begin
        filt_reserved = (filt_code > `SRF_FILT_LAST_LEGAL);
        filt_sel      = filt_reserved ? SRF_FILT_FIR : srf_filter_t'(filt_code);
    end

endmodule

/* srf_regs.sv */
/*
 * Status and rate/filter register bank of a delta-sigma converter.
 * Assumes the command decoder delivers one-cycle strobes on clk_sys with
 * a 5-bit register address, and that monitor inputs are synchronous.
 */
`include "srf_defines.svh"

module srf_regs
    import srf_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    // Register commands
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [4:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic [7:0]      reg_rdata,
    output logic            reg_rvalid,
    output logic            reg_wr_ignored,
    // Lock commands
    input  wire logic       lock_cmd,
    input  wire logic       unlock_cmd,
    // Events from the converter
    input  wire logic       crc_err_evt,
    input  wire logic       conv_start,
    input  wire logic       amp_low_det,
    input  wire logic       amp_high_det,
    input  wire logic       vref_low_det,
    input  wire logic       data_ready_evt,
    input  wire logic       data_read,
    input  wire logic       ext_clk_sel,
    // Configuration out
    output logic [4:0]      rate_code,
    output srf_filter_t     filter_sel,
    output srf_rate_t       rate_dsps,
    output logic            filter_reserved,
    output logic            conv_restart
);

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    logic       lock_q,        lock_d;
    logic       crc_q,         crc_d;
    logic       amp_lo_q,      amp_lo_d;
    logic       amp_hi_q,      amp_hi_d;
    logic       vref_lo_q,     vref_lo_d;
    logic       new_data_q,    new_data_d;
    logic       clk_src_q,     clk_src_d;
    logic       rst_flag_q,    rst_flag_d;
    logic [7:0] rate_filt_q,   rate_filt_d;
    logic [7:0] rdata_q,       rdata_d;
    logic       rvalid_q,      rvalid_d;
    logic       restart_q,     restart_d;
    logic       ignored_q,     ignored_d;

    logic       wr_ok;
    logic       wr_status;
    logic       wr_rate;
    logic [7:0] status_word;

    // ------------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------------
    function automatic logic addr_is(input logic [4:0] addr, input logic [4:0] target);
        return addr == target;
    endfunction

    // ------------------------------------------------------------------------
    // Write qualification
    // ------------------------------------------------------------------------
    assign wr_ok     = reg_wr && !lock_q;
    assign wr_status = wr_ok && addr_is(reg_addr, `SRF_ADDR_STATUS);
    assign wr_rate   = wr_ok && addr_is(reg_addr, `SRF_ADDR_RATE_FILT);

    always_comb begin
        status_word                    = 8'h00;
        status_word[`SRF_ST_LOCK]      = lock_q;
        status_word[`SRF_ST_CRC]       = crc_q;
        status_word[`SRF_ST_AMP_LO]    = amp_lo_q;
        status_word[`SRF_ST_AMP_HI]    = amp_hi_q;
        status_word[`SRF_ST_VREF_LO]   = vref_lo_q;
        status_word[`SRF_ST_NEW_DATA]  = new_data_q;
        status_word[`SRF_ST_CLOCK]     = clk_src_q;
        status_word[`SRF_ST_RESET]     = rst_flag_q;
    end

    // ------------------------------------------------------------------------
    // Write lock
    // ------------------------------------------------------------------------
    always_comb begin
        lock_d = lock_q;
        // Lock applied last, so it wins over a simultaneous unlock
        if (unlock_cmd) begin
            lock_d = 1'b0;
        end
        if (lock_cmd) begin
            lock_d = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            lock_q <= 1'b0;
        end else begin
            lock_q <= lock_d;
        end
    end

    // ------------------------------------------------------------------------
    // Sticky checksum error and reset indicator
    // ------------------------------------------------------------------------
    always_comb begin
        crc_d      = crc_q;
        rst_flag_d = rst_flag_q;
        // Host write first, a hardware set in the same cycle wins
        if (wr_status) begin
            crc_d      = reg_wdata[`SRF_ST_CRC];
            rst_flag_d = reg_wdata[`SRF_ST_RESET];
        end
        if (crc_err_evt) begin
            crc_d = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            crc_q      <= 1'b0;
            rst_flag_q <= 1'b1;
        end else begin
            crc_q      <= crc_d;
            rst_flag_q <= rst_flag_d;
        end
    end

    // ------------------------------------------------------------------------
    // Voltage alarms
    // ------------------------------------------------------------------------
    always_comb begin
        amp_lo_d  = amp_lo_q;
        amp_hi_d  = amp_hi_q;
        vref_lo_d = vref_lo_q;
        // Clear on conversion start; detection in the same cycle wins
        if (conv_start) begin
            amp_lo_d  = 1'b0;
            amp_hi_d  = 1'b0;
            vref_lo_d = 1'b0;
        end
        if (amp_low_det) begin
            amp_lo_d = 1'b1;
        end
        if (amp_high_det) begin
            amp_hi_d = 1'b1;
        end
        if (vref_low_det) begin
            vref_lo_d = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            amp_lo_q  <= 1'b0;
            amp_hi_q  <= 1'b0;
            vref_lo_q <= 1'b0;
        end else begin
            amp_lo_q  <= amp_lo_d;
            amp_hi_q  <= amp_hi_d;
            vref_lo_q <= vref_lo_d;
        end
    end

    // ------------------------------------------------------------------------
    // New data flag
    // ------------------------------------------------------------------------
    always_comb begin
        new_data_d = new_data_q;
        if (data_read) begin
            new_data_d = 1'b0;
        end
        if (data_ready_evt) begin
            new_data_d = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            new_data_q <= 1'b0;
        end else begin
            new_data_q <= new_data_d;
        end
    end

    // ------------------------------------------------------------------------
    // Clock source
    // ------------------------------------------------------------------------
    always_comb begin
        clk_src_d = ext_clk_sel;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            clk_src_q <= 1'b0;
        end else begin
            clk_src_q <= clk_src_d;
        end
    end

    // ------------------------------------------------------------------------
    // Rate and filter configuration
    // ------------------------------------------------------------------------
    always_comb begin
        rate_filt_d = rate_filt_q;
        if (wr_rate) begin
            rate_filt_d = reg_wdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            rate_filt_q <= `SRF_RATE_FILT_RST;
        end else begin
            rate_filt_q <= rate_filt_d;
        end
    end

    // ------------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------------
    always_comb begin
        rdata_d  = rdata_q;
        rvalid_d = reg_rd;
        // Data holds until the next read; unmapped reads give zero
        if (reg_rd) begin
            rdata_d = 8'h00;
            if (addr_is(reg_addr, `SRF_ADDR_STATUS)) begin
                rdata_d = status_word;
            end else if (addr_is(reg_addr, `SRF_ADDR_RATE_FILT)) begin
                rdata_d = rate_filt_q;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            rdata_q  <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    // ------------------------------------------------------------------------
    // Write outcome pulses
    // ------------------------------------------------------------------------
    always_comb begin
        restart_d = wr_rate;
        ignored_d = reg_wr && lock_q;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            restart_q <= 1'b0;
            ignored_q <= 1'b0;
        end else begin
            restart_q <= restart_d;
            ignored_q <= ignored_d;
        end
    end

    // ------------------------------------------------------------------------
    // Decoders
    // ------------------------------------------------------------------------
    assign rate_code = rate_filt_q[`SRF_RATE_HI:`SRF_RATE_LO];

    srf_rate_decode u_rate (
        .rate_code (rate_code),
        .rate_dsps (rate_dsps)
    );

    srf_filter_decode u_filt (
        .filt_code     (rate_filt_q[`SRF_FILT_HI:`SRF_FILT_LO]),
        .filt_sel      (filter_sel),
        .filt_reserved (filter_reserved)
    );

    assign reg_rdata      = rdata_q;
    assign reg_rvalid     = rvalid_q;
    assign conv_restart   = restart_q;
    assign reg_wr_ignored = ignored_q;

endmodule

/* srf_regs_chk.sv */
/*
 * Port checker for the status and rate/filter register bank.
 * Assumes one clock domain, reset synchronous and active low.
 */
module srf_regs_chk
    import srf_pkg::*;
(
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        rst_b,
    // Register commands
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [4:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic [7:0]  reg_rdata,
    input wire logic        reg_rvalid,
    input wire logic        reg_wr_ignored,
    input wire logic        lock_cmd,
    input wire logic        unlock_cmd,
    // Configuration
    input wire logic [4:0]  rate_code,
    input wire srf_filter_t filter_sel,
    input wire srf_rate_t   rate_dsps,
    input wire logic        filter_reserved,
    input wire logic        conv_restart
);
    timeunit 1ns;
    timeprecision 100ps;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    sequence s_open_wr;
        (unlock_cmd && !lock_cmd) ##1 !lock_cmd ##1 (reg_wr && reg_addr == 5'h02 && !lock_cmd);
    endsequence

    sequence s_shut_wr;
        lock_cmd ##1 !unlock_cmd ##1 reg_wr;
    endsequence

    AST_RVALID: assert property (reg_rd |=> reg_rvalid) else $error("read not answered");
    AST_RDATA_HOLD: assert property (!reg_rvalid |-> $stable(reg_rdata)) else $error("read data moved");
    AST_OPEN_WR: assert property (s_open_wr |=> conv_restart && !reg_wr_ignored
        && rate_code == $past(reg_wdata[7:3])) else $error("open write not applied");
    AST_SHUT_WR: assert property (s_shut_wr |=> reg_wr_ignored && !conv_restart)
        else $error("locked write not ignored");
    AST_IGN_CAUSE: assert property (reg_wr_ignored |-> $past(reg_wr)) else $error("stray ignore");
    AST_RST_CAUSE: assert property (conv_restart |-> $past(reg_wr && reg_addr == 5'h02))
        else $error("stray restart");
    AST_RATE_HOLD: assert property (!(reg_wr && reg_addr == 5'h02) |=> $stable(rate_code))
        else $error("rate code moved");
    AST_FILT_RSV: assert property (conv_restart |-> !filter_reserved
        && 3'(filter_sel) == $past(reg_wdata[2:0])) else $error("filter decode");
    AST_RATE_TOP: assert property (rate_code[4] |-> rate_dsps == 20'd400000) else $error("top rate");
    AST_RATE_DFLT: assert property (rate_code == 5'h04 |-> rate_dsps == 20'd200) else $error("rate 4");
endmodule

bind srf_regs srf_regs_chk u_chk (.clk_sys, .rst_b, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .reg_rvalid, .reg_wr_ignored, .lock_cmd, .unlock_cmd, .rate_code, .filter_sel,
    .rate_dsps, .filter_reserved, .conv_restart);

/* srf_host.sv */
/*
 * Host model issuing register and lock commands.
 * Assumes the bank answers reads one cycle after the strobe.
 */
module srf_host (
    // Clock
    input  wire logic       clk_sys,
    // Commands
    output logic            reg_wr,
    output logic            reg_rd,
    output logic [4:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    output logic            lock_cmd,
    output logic            unlock_cmd,
    // Answer
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rvalid
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        {reg_wr, reg_rd, lock_cmd, unlock_cmd} = '0;
        reg_addr = '0;
        reg_wdata = '0;
    end

    // One-cycle write strobe; an unlocked status write loads the checksum and reset bits from the data
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask

    task automatic rd(input logic [4:0] a, output logic [7:0] d, output logic v);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        #1;
        d = reg_rdata;
        v = reg_rvalid;
    endtask

    task automatic cmd(input logic l, input logic u);
        @(posedge clk_sys);
        lock_cmd <= l;
        unlock_cmd <= u;
        @(posedge clk_sys);
        {lock_cmd, unlock_cmd} <= 2'b00;
    endtask
endmodule

/* testbench.sv */
/*
 * Self-checking bench for the register bank against a behavioural model.
 * Assumes srf_host drives the register commands.
 */
module testbench
    import srf_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic [6:0] evts = '0;
    logic ext = 1'b0;
    logic reg_wr, reg_rd, lock_cmd, unlock_cmd, reg_rvalid, reg_wr_ignored, filter_reserved, conv_restart;
    logic [4:0] reg_addr, rate_code;
    logic [7:0] reg_wdata, reg_rdata, st, md;
    srf_filter_t filter_sel;
    srf_rate_t rate_dsps;
    int n_fail = 0;
    int check_count = 0;
    int cyc = 0;
    logic [31:0] r;

    always #2.5 clk_sys = ~clk_sys;

    srf_host host (.clk_sys, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .lock_cmd, .unlock_cmd,
        .reg_rdata, .reg_rvalid);

    srf_regs dut (.clk_sys, .rst_b, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid,
        .reg_wr_ignored, .lock_cmd, .unlock_cmd, .crc_err_evt(evts[6]), .conv_start(evts[5]),
        .amp_low_det(evts[4]), .amp_high_det(evts[3]), .vref_low_det(evts[2]),
        .data_ready_evt(evts[1]), .data_read(evts[0]), .ext_clk_sel(ext), .rate_code,
        .filter_sel, .rate_dsps, .filter_reserved, .conv_restart);

    function automatic int rate_of(int c);
        int t[16] = '{25, 50, 100, 166, 200, 500, 600, 1000, 4000, 12000, 24000, 48000, 72000,
            144000, 192000, 256000};
        return c > 15 ? 400000 : t[c];
    endfunction

    task automatic complete_run;
        $display("Checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [19:0] e, input logic [19:0] g);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic rdc(input logic [4:0] a);
        logic [7:0] d;
        logic v;
        host.rd(a, d, v);
        chk("rvalid", 1, v);
        chk("rdata", a == 5'h01 ? {st[7:2], ext, st[0]} : a == 5'h02 ? md : 8'h00, d);
    endtask

    task automatic wrc(input logic [4:0] a, input logic [7:0] d);
        logic lk;
        lk = st[7];
        host.wr(a, d);
        #1;
        chk("conv_restart", a == 5'h02 && !lk, conv_restart);
        chk("reg_wr_ignored", lk, reg_wr_ignored);
        if (!lk && a == 5'h02) md = d;
        if (!lk && a == 5'h01) st = (st & 8'hbe) | (d & 8'h41);
        chk("rate_code", md[7:3], rate_code);
        chk("rate_dsps", rate_of(md[7:3]), rate_dsps);
        chk("filter_sel", md[2:0] > 4 ? 4 : md[2:0], filter_sel);
        chk("filter_reserved", md[2:0] > 4, filter_reserved);
    endtask

    // One cycle of converter events, model sets after clears
    task automatic ev(input logic [6:0] e, input logic x);
        @(posedge clk_sys);
        evts <= e;
        ext <= x;
        @(posedge clk_sys);
        evts <= '0;
        if (e[5]) st &= 8'hc7;
        st |= {e[6], e[4:1], 2'b00};
        if (e[0] && !e[1]) st &= 8'hfb;
    endtask

    task automatic do_reset(input int n);
        @(posedge clk_sys);
        rst_b <= 1'b0;
        repeat (n) @(posedge clk_sys);
        rst_b <= 1'b1;
        st = 8'h01;
        md = 8'h24;
    endtask

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            complete_run();
        end
    end

    initial begin
        r = $urandom(54);
        do_reset(20);
        rdc(5'h02);
        rdc(5'h01);
        rdc(5'h1f);
        for (int i = 0; i < 32; i++)
            wrc(5'h02, {i[4:0], 3'(i % 5)});
        rdc(5'h02);
        repeat (80) begin
            r = $urandom;
            ev(r[22:16], r[23]);
            if (r[1:0] == 2'b00) begin
                host.cmd(r[2], r[3]);
                if (r[2] || r[3]) st[7] = r[2];
            end
            if (r[4]) wrc(r[5] ? 5'h01 : 5'h02, {r[15:11], 3'(r[10:8] % 5)});
            rdc(5'h01);
        end
        do_reset(3);
        rdc(5'h01);
        rdc(5'h02);
        complete_run();
    end
endmodule
